// >>> src/pll_clock_source_startup.v
/*
  Clock source selection, multiplying loop control and start-up
  sequencing, with software access over an AXI4-Lite slave.
  Assumes all inputs synchronous to core_clk; oscillators are modelled
  by tick inputs and rate outputs, not by real clocks.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.

`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_defines.vh"

module pll_clock_source_startup #(
  parameter       WDT_LONG_CYCLES = `WDT_LONG,
  parameter       LOCK_CYCLES     = `LOCK_CYCLES,
  parameter [7:0] TRIM_RESET      = `TRIM_RESET,
  parameter [7:0] TRIM_NOMINAL    = `TRIM_NOMINAL
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_b,
  // AXI4-Lite write address
  input  wire [3:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Fuses
  input  wire [3:0]       clk_source_fuses,
  input  wire [1:0]       startup_time_fuses,
  // Time bases and power control
  input  wire             srcTick,
  input  wire             wdtTick,
  input  wire             deepSleepReq,
  input  wire             wakeEvent,
  // Oscillator and loop settings
  output reg              rcOscOn,
  output reg              loopOn,
  output reg  [3:0]       loopMult,
  output reg              loopSrcHalf,
  output reg  [16:0]      rcRateKhz,
  output reg  [16:0]      fastPeriphKhz,
  output reg              loopSaturated,
  // Clock routing
  output reg  [2:0]       sysClkSel,
  output reg              sysClkDiv4,
  output reg              timerFastClk,
  output reg              timerPrescaled,
  // Status
  output wire             loopLocked,
  output wire             cpuRun
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg        loopEnable_reg;     // Software loop enable
  reg        lowSpeed_reg;       // Low speed select
  reg        timerFast_reg;      // Timer takes fast clock
  reg        timerPresc_reg;     // Timer takes prescaled fast clock
  reg [7:0]  oscTrim_reg;        // RC oscillator trim
  // Reset leaves the loop to the fuses

  // ----------------------------------------------------------------
  // Fuse decode
  // ----------------------------------------------------------------
  // Fuse codes that force the loop on
  wire fuseLoop   = (clk_source_fuses == `SRC_LOOP);
  wire fuseCompat = (clk_source_fuses == `SRC_RC_COMPAT);
  wire inDeepSleep;

  // Map four fuse bits onto a source; the upper half is crystal
  always @* begin
    case (clk_source_fuses)
      `SRC_EXTERNAL:  sysClkSel = `SYS_EXTERNAL;
      `SRC_LOOP:      sysClkSel = `SYS_LOOP;
      `SRC_RC:        sysClkSel = `SYS_RC;
      `SRC_RC_COMPAT: sysClkSel = `SYS_RC_COMPAT;
      `SRC_LOW_POWER: sysClkSel = `SYS_LOW_POWER;
      `SRC_LF_XTAL:   sysClkSel = `SYS_LF_XTAL;
      `SRC_RES_A, `SRC_RES_B: sysClkSel = `SYS_RESERVED;
      // Upper half of the codes: crystal
      default:        sysClkSel = `SYS_XTAL;
    endcase
  end

  // ----------------------------------------------------------------
  // Loop and oscillator control
  // ----------------------------------------------------------------
  // Loop runs from fuses alone so a loop-clocked part always starts
  always @* begin
    loopOn  = (loopEnable_reg || fuseLoop || fuseCompat)
              && !inDeepSleep;
    rcOscOn = !inDeepSleep;
    // Legacy mode fixes rate and factor
    loopMult    = fuseCompat ? `LOOP_MULT_COMPAT
                             : `LOOP_MULT_NORMAL;
    // Low speed ignored in legacy mode
    loopSrcHalf = lowSpeed_reg && !fuseCompat;
    rcRateKhz   = fuseCompat ? `RC_COMPAT_KHZ
                             : `RC_NOMINAL_KHZ;
  end

  // Over-range trim pins the fast clock at its ceiling
  always @* begin
    loopSaturated = loopOn && (oscTrim_reg > TRIM_NOMINAL);
    // Saturation wins: lock is lost
    if (!loopOn)
      fastPeriphKhz = 17'h00000;
    else if (loopSaturated)
      fastPeriphKhz = `FAST_CLK_MAX_KHZ;
    else if (fuseCompat)
      fastPeriphKhz = 17'd25600;
    else if (loopSrcHalf)
      fastPeriphKhz = 17'd32000;
    else
      fastPeriphKhz = 17'd64000;
  end

  // System clock divided by four for loop and compatibility sources
  always @* begin
    sysClkDiv4     = fuseLoop
                     || fuseCompat;
    // Timer routes only while loop runs
    timerFastClk   = timerFast_reg && loopOn;
    timerPrescaled = timerPresc_reg && loopOn;
  end

  // ----------------------------------------------------------------
  // Lock detection and start-up sequencing
  // ----------------------------------------------------------------
  // Lock restarts on drop or saturation
  loop_lock_detect #(
    .LOCK_CYCLES (LOCK_CYCLES),
    .CNT_W       (11)
  ) u_lock (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .loopOn    (loopOn),
    .saturated (loopSaturated),
    .lockFlag  (loopLocked)
  );

  // Source ticks are taken as steady; the far side
  // keeps the external clock within its slew limit
  startup_sequencer #(
    .WDT_SHORT_CYCLES (`WDT_SHORT),
    .WDT_LONG_CYCLES  (WDT_LONG_CYCLES)
  ) u_seq (
    .core_clk         (core_clk),
    .rst_b            (rst_b),
    .srcTick          (srcTick),
    .wdtTick          (wdtTick),
    .clkSourceFuses   (clk_source_fuses),
    .startupTimeFuses (startup_time_fuses),
    .deepSleepReq     (deepSleepReq),
    .wakeEvent        (wakeEvent),
    .cpuRun           (cpuRun),
    .inDeepSleep      (inDeepSleep)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  reg        awHeld_reg;         // Address taken, awaiting data
  reg        wHeld_reg;          // Data taken, awaiting address
  reg [3:0]  awAddr_reg;         // Latched write address
  reg [31:0] wData_reg;          // Latched write data
  reg [3:0]  wStrb_reg;          // Latched byte strobes

  // Each channel stalls only while its own item is held or answered
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;

  // A held item waits for its partner
  wire        awTake = s_axi_awvalid && s_axi_awready;
  wire        wTake  = s_axi_wvalid && s_axi_wready;
  wire        awHave = awHeld_reg || awTake;
  wire        wHave  = wHeld_reg || wTake;
  wire        doWrite = awHave && wHave;
  // Held copies win over the bus
  wire [3:0]  wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire        wrLow  = wrStrb[0];
  wire        wrCtrl = doWrite && wrLow && (wrAddr == `OFS_LOOP_CTRL);
  wire        wrTrim = doWrite && wrLow && (wrAddr == `OFS_OSC_TRIM);
  wire        wrMapped = (wrAddr == `OFS_LOOP_CTRL) || (wrAddr == `OFS_OSC_TRIM)
                         || (wrAddr == `OFS_CLK_STATUS);

  // Handshake bookkeeping and response
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= 4'h0;
      wData_reg    <= 32'h00000000;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      // Latch whichever half arrives first
      if (awTake) begin
        awAddr_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      // Both halves present: commit
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? 2'h0 : 2'h2;   // Slave error if unmapped
      end else begin
        awHeld_reg <= awHave;
        wHeld_reg  <= wHave;
        // Response stands until taken
        if (s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates; writes to the status word are ignored
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loopEnable_reg <= 1'b0;
      lowSpeed_reg   <= 1'b0;
      timerFast_reg  <= 1'b0;
      timerPresc_reg <= 1'b0;
      oscTrim_reg    <= TRIM_RESET;
    end else begin
      // Only byte lane zero holds bits
      if (wrCtrl) begin
        loopEnable_reg <= wrData[`BIT_LOOP_ENABLE];
        timerFast_reg  <= wrData[`BIT_TIMER_FAST];
        timerPresc_reg <= wrData[`BIT_TIMER_PRESC];
        // Setting is refused while the loop clocks the system
        if (!wrData[`BIT_LOW_SPEED])
          lowSpeed_reg <= 1'b0;
        else if (!fuseLoop && !fuseCompat)
          lowSpeed_reg <= 1'b1;
      end
      // Any trim value is accepted
      if (wrTrim)
        oscTrim_reg <= wrData[7:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  reg [31:0] rdWord;             // Word at the requested offset
  reg        rdHit;              // Offset is mapped

  // One read in flight; a new address waits for the data to drain
  assign s_axi_arready = !s_axi_rvalid;

  // Read multiplexer
  always @* begin
    rdWord = 32'h00000000;
    rdHit  = 1'b1;
    case (s_axi_araddr)
      `OFS_LOOP_CTRL: begin
        rdWord[`BIT_LOOP_ENABLE] = loopEnable_reg;
        rdWord[`BIT_LOW_SPEED]   = lowSpeed_reg;
        rdWord[`BIT_LOOP_LOCK]   = loopLocked;
        rdWord[`BIT_TIMER_FAST]  = timerFast_reg;
        rdWord[`BIT_TIMER_PRESC] = timerPresc_reg;
      end
      `OFS_OSC_TRIM: begin
        rdWord[7:0] = oscTrim_reg;
      end
      // Status mirrors fuses and state
      `OFS_CLK_STATUS: begin
        rdWord[`BIT_CPU_RUN]   = cpuRun;
        rdWord[`BIT_SATURATED] = loopSaturated;
        rdWord[`BIT_COMPAT]    = fuseCompat;
        rdWord[`BIT_LOOP_ON]   = loopOn;
        rdWord[`FLD_FUSES_HI:`FLD_FUSES_LO] = clk_source_fuses;
        rdWord[`FLD_SUT_HI:`FLD_SUT_LO]     = startup_time_fuses;
      end
      default: begin
        // Unmapped: zero and slave error
        rdHit = 1'b0;
      end
    endcase
  end

  // Read data register
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      // Answer the cycle after accept
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= rdHit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      // Data drains on the ready edge
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> src/pll_clock_defines.vh
/*
  Constants for the loop clock source and start-up block: register
  offsets, field positions, reset values, fuse codes and timing counts.
  Assumes inclusion by bare name from each design file that needs it.
*/
`ifndef PLL_CLOCK_DEFINES_VH
`define PLL_CLOCK_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_LOOP_CTRL      4'h0
`define OFS_OSC_TRIM       4'h4
`define OFS_CLK_STATUS     4'h8

// ----------------------------------------------------------------
// Loop control/status fields
// ----------------------------------------------------------------
`define BIT_LOOP_ENABLE    0
`define BIT_LOW_SPEED      1
`define BIT_LOOP_LOCK      2
`define BIT_TIMER_FAST     3
`define BIT_TIMER_PRESC    4

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BIT_CPU_RUN        0
`define BIT_SATURATED      1
`define BIT_COMPAT         2
`define BIT_LOOP_ON        3
`define FLD_FUSES_LO       4
`define FLD_FUSES_HI       7
`define FLD_SUT_LO         8
`define FLD_SUT_HI         9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TRIM_RESET         8'h80
`define TRIM_NOMINAL       8'h80

// ----------------------------------------------------------------
// Clock source fuse codes
// ----------------------------------------------------------------
`define SRC_EXTERNAL       4'h0
`define SRC_LOOP           4'h1
`define SRC_RC             4'h2
`define SRC_RC_COMPAT      4'h3
`define SRC_LOW_POWER      4'h4
`define SRC_RES_A          4'h5
`define SRC_LF_XTAL        4'h6
`define SRC_RES_B          4'h7

// Decoded system clock source
`define SYS_EXTERNAL       3'h0
`define SYS_LOOP           3'h1
`define SYS_RC             3'h2
`define SYS_RC_COMPAT      3'h3
`define SYS_LOW_POWER      3'h4
`define SYS_LF_XTAL        3'h5
`define SYS_XTAL           3'h6
`define SYS_RESERVED       3'h7

// ----------------------------------------------------------------
// Start-up time fuse codes and cycle counts
// ----------------------------------------------------------------
`define SUT_00             2'h0
`define SUT_01             2'h1
`define SUT_10             2'h2
`define SUT_11             2'h3
`define WAKE_CK            14'd6
`define WAKE_CK_FAST       14'd1
`define RESET_CK           14'd14
`define WDT_SHORT          512
`define WDT_LONG           8192

// ----------------------------------------------------------------
// Loop rates in kHz and multipliers
// ----------------------------------------------------------------
`define RC_NOMINAL_KHZ     17'd8000
`define RC_COMPAT_KHZ      17'd6400
`define LOOP_MULT_NORMAL   4'd8
`define LOOP_MULT_COMPAT   4'd4
`define FAST_CLK_MAX_KHZ   17'd85000

// ----------------------------------------------------------------
// Lock settle time
// ----------------------------------------------------------------
`define CLK_MHZ            10
`define LOCK_TIME_US       100
`define LOCK_CYCLES        (`LOCK_TIME_US * `CLK_MHZ)

`endif

// >>> src/loop_lock_detect.v
/*
  Lock detector for the clock multiplying loop: counts settle cycles
  after enable and raises the lock flag once the loop has stabilised.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_defines.vh"

module loop_lock_detect #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter CNT_W       = 11
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_b,
  // Loop state
  input  wire             loopOn,
  input  wire             saturated,
  // Lock result
  output reg              lockFlag
);

  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] settle_reg;     // Cycles since loop came up
  localparam integer     LOCK_LAST_INT = LOCK_CYCLES - 1;
  localparam [CNT_W-1:0] LOCK_LAST     = LOCK_LAST_INT[CNT_W-1:0];

  // Restart on any loss of enable or any over-range trim
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= {CNT_W{1'b0}};
      lockFlag   <= 1'b0;
    end else if (!loopOn || saturated) begin
      settle_reg <= {CNT_W{1'b0}};
      lockFlag   <= 1'b0;
    end else if (settle_reg == LOCK_LAST) begin
      lockFlag   <= 1'b1;
    end else begin
      settle_reg <= settle_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// >>> src/startup_sequencer.v
/*
  Start-up sequencer: holds instruction execution after reset and after
  wake from deep sleep until the fuse-selected delay has been counted.
  Assumes srcTick pulses once per selected source cycle and wdtTick
  once per watchdog oscillator cycle, both synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_defines.vh"

module startup_sequencer #(
  parameter WDT_SHORT_CYCLES = `WDT_SHORT,
  parameter WDT_LONG_CYCLES  = `WDT_LONG
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_b,
  // Time bases
  input  wire             srcTick,
  input  wire             wdtTick,
  // Fuses
  input  wire [3:0]       clkSourceFuses,
  input  wire [1:0]       startupTimeFuses,
  // Deep sleep control
  input  wire             deepSleepReq,
  input  wire             wakeEvent,
  // Status
  output reg              cpuRun,
  output wire             inDeepSleep
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_RST_CK  = 3'h0;  // Reset: source cycles
  localparam [2:0] ST_RST_WDT = 3'h1;  // Reset: watchdog cycles
  localparam [2:0] ST_RUN     = 3'h2;  // Executing
  localparam [2:0] ST_SLEEP   = 3'h3;  // Oscillators stopped
  localparam [2:0] ST_WAKE    = 3'h4;  // Wake: source cycles

  reg  [2:0]  state_reg;     // Current state
  reg  [2:0]  state_next;
  reg  [13:0] count_reg;     // Cycles still to wait
  reg  [13:0] count_next;
  reg  [13:0] wdtDelay;      // Reset delay chosen by fuses
  reg  [13:0] wakeDelay;     // Wake delay chosen by fuses
  wire        compat = (clkSourceFuses == `SRC_RC_COMPAT);

  assign inDeepSleep = (state_reg == ST_SLEEP);

  // ----------------------------------------------------------------
  // Delay selection
  // ----------------------------------------------------------------
  // Compatibility mode orders its codes differently; reserved code 11
  // of the other sources falls back to the long delay as safest.
  always @* begin
    wakeDelay = `WAKE_CK;
    if (compat && startupTimeFuses == `SUT_11)
      wakeDelay = `WAKE_CK_FAST;
    if (compat) begin
      case (startupTimeFuses)
        `SUT_00, `SUT_01: wdtDelay = WDT_LONG_CYCLES[13:0];
        `SUT_10:          wdtDelay = WDT_SHORT_CYCLES[13:0];
        default:          wdtDelay = 14'h0000;
      endcase
    end else begin
      case (startupTimeFuses)
        `SUT_00: wdtDelay = 14'h0000;
        `SUT_01: wdtDelay = WDT_SHORT_CYCLES[13:0];
        default: wdtDelay = WDT_LONG_CYCLES[13:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ST_RST_CK: begin
        if (srcTick) begin
          if (count_reg == 14'h0001) begin
            state_next = (wdtDelay == 14'h0000) ? ST_RUN : ST_RST_WDT;
            count_next = wdtDelay;
          end else begin
            count_next = count_reg - 14'h0001;
          end
        end
      end
      ST_RST_WDT: begin
        // Real-time part timed on the watchdog oscillator
        if (wdtTick) begin
          if (count_reg == 14'h0001)
            state_next = ST_RUN;
          count_next = count_reg - 14'h0001;
        end
      end
      ST_RUN: begin
        if (deepSleepReq)
          state_next = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          state_next = ST_WAKE;
          count_next = wakeDelay;
        end
      end
      ST_WAKE: begin
        // Selected source times the wake-up
        if (srcTick) begin
          if (count_reg == 14'h0001)
            state_next = ST_RUN;
          count_next = count_reg - 14'h0001;
        end
      end
      default: begin
        state_next = ST_RST_CK;
        count_next = `RESET_CK;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_RST_CK;
      count_reg <= `RESET_CK;
      cpuRun    <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      cpuRun    <= (state_next == ST_RUN);
    end
  end

endmodule
`default_nettype wire

// >>> tb/pll_clock_checker_asserts.sv
/* Checker on the clock source block's top-level ports.
   Assumes one clock domain and the bind below. */
`timescale 1ns/10ps
`default_nettype none
module pll_clock_checker (
  input wire logic core_clk, rst_b, cpuRun, deepSleepReq, loopOn, rcOscOn,
  input wire logic loopSaturated, loopSrcHalf, loopLocked, sysClkDiv4,
  input wire logic [3:0] clk_source_fuses, loopMult,
  input wire logic [16:0] fastPeriphKhz
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire compat = clk_source_fuses == 4'h3; // Legacy mode code
  wire loopSys = compat | (clk_source_fuses == 4'h1); // Loop forced on
  sequence s_nap; cpuRun && deepSleepReq; endsequence
  a_loop_mult: assert property (loopMult == (compat ? 4'h4 : 4'h8))
    else $error("loop multiplier wrong");
  a_compat_half: assert property (compat |-> !loopSrcHalf)
    else $error("source halved in legacy mode");
  a_fuse_enable: assert property (loopSys && cpuRun |-> loopOn)
    else $error("loop off although fuses need it");
  a_sleep_off: assert property (s_nap |=> !rcOscOn && !loopOn)
    else $error("oscillator running in sleep");
  a_lock_clear: assert property (!loopOn |=> !loopLocked)
    else $error("lock flag set with loop off");
  a_lock_settle: assert property ($rose(loopLocked) |-> $past(loopOn, 8))
    else $error("lock flag before settle time");
  a_div_four: assert property (sysClkDiv4 == loopSys)
    else $error("system divide by four wrong");
  a_sat_cap: assert property (loopSaturated |-> fastPeriphKhz == 17'h14c08)
    else $error("saturated rate wrong");
endmodule
bind pll_clock_source_startup pll_clock_checker chk (.*);
`default_nettype wire

// >>> tb/tick_source.sv
/* Time base model: source oscillator ticks every second cycle,
   watchdog oscillator ticks every cycle. Assumes a running clock. */
`timescale 1ns/10ps
`default_nettype none
module tick_source (input wire logic core_clk, output logic srcTick = 1'b0, output logic wdtTick);
  assign wdtTick = 1'b1; // Fastest watchdog rate shortens the run
  always @(posedge core_clk) srcTick <= !srcTick;
endmodule
`default_nettype wire

// >>> tb/pll_clock_source_startup_test.sv
/* Testbench for the clock source block with tick model.
   Assumes a shortened lock time and a shortened long watchdog delay. */
`timescale 1ns/10ps
`default_nettype none
module pll_clock_source_startup_test;
  logic core_clk = '0, rst_b = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
  logic s_axi_bready = '0, s_axi_rready = '0, deepSleepReq = '0, wakeEvent = '0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'h1, clk_source_fuses = 4'h2;
  logic [31:0] s_axi_wdata = '0, q;
  logic [1:0] startup_time_fuses = '0, rs;
  wire logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, srcTick, wdtTick;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic rcOscOn, loopOn, loopSrcHalf, loopSaturated, sysClkDiv4, timerFastClk, timerPrescaled;
  wire logic loopLocked, cpuRun;
  wire logic [3:0] loopMult;
  wire logic [16:0] rcRateKhz, fastPeriphKhz;
  wire logic [2:0] sysClkSel;
  int n_errors = 0, total_checks = 0, n, f;
  always #50 core_clk = !core_clk;
  pll_clock_source_startup #(.WDT_LONG_CYCLES(64), .LOCK_CYCLES(10)) dut (.*);
  tick_source ticks (.core_clk(core_clk), .srcTick(srcTick), .wdtTick(wdtTick));
  task finish_test;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // One write or read; both write channels offered together
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= w; s_axi_wvalid <= w; s_axi_bready <= w;
    s_axi_arvalid <= !w; s_axi_rready <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w && s_axi_bvalid) begin rs = s_axi_bresp; break; end
      if (!w && s_axi_rvalid) begin rs = s_axi_rresp; q = s_axi_rdata; break; end
    end
    s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
    if (k == 20) begin n_errors++; $display("[FAIL] %0t bus timeout", $time); finish_test(); end
  endtask
  task rst(input logic [3:0] fu, input logic [1:0] su);
    rst_b <= 1'b0; clk_source_fuses <= fu; startup_time_fuses <= su;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask
  // Cycles until execution starts, bounded
  task run_wait;
    n = 0;
    while (cpuRun !== 1'b1) begin
      @(posedge core_clk); n++;
      if (n > 3000) begin n_errors++; $display("[FAIL] %0t start timeout", $time); finish_test(); end
    end
  endtask
  task t_startup;
    rst(4'h0, 2'h1); run_wait; chk(n >= 535 && n <= 548, 1);
    rst(4'h0, 2'h2); run_wait; chk(n >= 88 && n <= 97, 1);
    rst(4'h0, 2'h0); run_wait; chk(n >= 26 && n <= 34, 1);
    bus(1, 4'h0, 32'h1);
    @(posedge core_clk) deepSleepReq <= 1'b1;
    @(posedge core_clk) deepSleepReq <= 1'b0;
    @(posedge core_clk) chk({cpuRun, rcOscOn, loopOn}, 0);
    wakeEvent <= 1'b1; @(posedge core_clk) wakeEvent <= 1'b0;
    run_wait; chk(n >= 9 && n <= 16, 1);
  endtask
  task t_loop;
    rst(4'h2, 2'h0); run_wait;
    bus(0, 4'h4, 0); chk(q, 32'h80);
    bus(0, 4'hc, 0); chk({rs, q}, {2'h2, 32'h0});
    bus(1, 4'h0, 32'h19); chk({rs, loopOn}, 3'h1); repeat (15) @(posedge core_clk);
    bus(0, 4'h0, 0); chk(q, 32'h1d);
    chk({timerFastClk, timerPrescaled, fastPeriphKhz}, {2'h3, 17'hfa00});
    bus(1, 4'h0, 32'h3); chk({loopSrcHalf, fastPeriphKhz}, {1'b1, 17'h7d00});
    bus(1, 4'h4, 32'h81); @(posedge core_clk); chk({loopSaturated, loopLocked}, 2'h2);
    bus(1, 4'h0, 0); @(posedge core_clk); bus(0, 4'h0, 0); chk(q, 0);
  endtask
  task t_modes;
    rst(4'h3, 2'h3); chk({loopMult, fastPeriphKhz, rcRateKhz}, {4'h4, 17'h6400, 17'h1900});
    run_wait; bus(0, 4'h8, 0); chk({rs, q}, {2'h0, 32'h33d});
    bus(1, 4'h0, 32'h2); bus(0, 4'h0, 0); chk(q[1], 0);
    rst(4'h1, 2'h0); run_wait; bus(1, 4'h0, 32'h2); bus(0, 4'h0, 0); chk(q[1], 0);
    for (f = 0; f < 16; f++) begin
      @(posedge core_clk) clk_source_fuses <= f[3:0];
      @(posedge core_clk); @(negedge core_clk);
      chk(sysClkSel, f > 7 ? 6 : (f == 5 || f == 7) ? 7 : f == 6 ? 5 : f);
      chk({loopOn, sysClkDiv4}, {2{f == 1 || f == 3}});
    end
  endtask
  initial begin
    t_startup; t_loop; t_modes;
    finish_test();
  end
endmodule
`default_nettype wire
